// *** core/motion_defines.vh ***
// Register map, field positions, reset values and timing constants of the motion core
`ifndef MOTION_DEFINES_VH
`define MOTION_DEFINES_VH

// Byte offsets
`define OFF_CTRL      12'h000
`define OFF_STATUS    12'h004
`define OFF_IRQ_STAT  12'h008
`define OFF_IRQ_MASK  12'h00C
`define OFF_VMIN      12'h010
`define OFF_VMAX      12'h014
`define OFF_RAMP      12'h018
`define OFF_CFG       12'h01C
`define OFF_POS       12'h020
`define OFF_TARGET    12'h024

// Control register fields (write strobes, read as zero)
`define CTRL_START_EXT 0
`define CTRL_START_INT 1
`define CTRL_START_POS 2
`define CTRL_ACK       3
`define CTRL_ABORT     4
`define CTRL_INVALID   5

// Config register fields
`define CFG_SW_NC      0
`define CFG_REF_BEH_LO 1
`define CFG_REF_BEH_HI 2
`define CFG_NRM_BEH_LO 3
`define CFG_NRM_BEH_HI 4
`define CFG_DIR        5
`define CFG_RESET      6'h00

// Switch behaviours
`define BEH_REVERSE  2'h0
`define BEH_CONTINUE 2'h1
`define BEH_STOP     2'h2
`define BEH_IGNORE   2'h3

// Interrupt / status bits
`define EV_REF_DONE  0
`define EV_LIMIT     1
`define EV_POS_ERR   2
`define EV_INVALID   3
`define EV_OVERTEMP  4
`define EV_UNDERVOLT 5
`define EV_MOVE_DONE 6
`define EV_COUNT     7

// Reset values
`define VMIN_RESET   16'h0064
`define VMAX_RESET   16'h03E8
`define RAMP_RESET   16'h000A

// Timing
`define CLK_HZ        200000000
`define PAUSE_MS      100
`define PAUSE_CYCLES  ((`CLK_HZ / 1000) * `PAUSE_MS)
`define DEBOUNCE_CYC  16
`define RATE_ACC_BITS 32

`endif

// *** core/ref_limit_motion.v ***
// Reference-run and limit-switch motion core with APB register access
// Notes on behaviour
// - External run ramps minimum to maximum speed
// - Switch hit halts, then 100 ms pause
// - Then leave switch at minimum speed
// - Switch polarity: normally closed or open
// - Internal run at minimum speed, no ramp
// - Shaft mark recurs once per revolution
// - Separate behaviour for reference and normal
// - Four behaviours, stop/ignore normal only
// - Reverse: turn back until switch releases
// - Continue: keep direction until switch releases
// - Stop: no step in detection cycle
// - Ignore: switch has no effect normally
// - Reference reached drives outputs 1 and 2
// - Position error or limit latches until acknowledged; position error is only checked during positioning moves
// - Overtemperature or undervoltage lights error lamp
// - Ramp starts at minimum, ends at maximum
//
// The APB register port and the register offsets were decided locally.
`include "motion_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module ref_limit_motion #(
   parameter [31:0] PAUSE_CYCLES = `PAUSE_CYCLES
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   input  wire        ref_switch,
   input  wire        shaft_mark,
   input  wire        position_error,
   input  wire        overtemp,
   input  wire        undervolt,
   output reg         step,
   output reg         dir,
   output reg         out1,
   output reg         out2,
   output wire        error_led,
   output wire        irq
);

   // ==========================================================
   // State encoding
   localparam [7:0] ST_IDLE   = 8'h01;
   localparam [7:0] ST_EXT    = 8'h02;
   localparam [7:0] ST_PAUSE  = 8'h04;
   localparam [7:0] ST_LEAVE  = 8'h08;
   localparam [7:0] ST_INT    = 8'h10;
   localparam [7:0] ST_POS    = 8'h20;
   localparam [7:0] ST_ERROR  = 8'h40;
   localparam [7:0] ST_LIMLV  = 8'h80;

   reg [7:0]  state;
   reg [7:0]  next_state;
   reg [15:0] vmin;
   reg [15:0] vmax;
   reg [15:0] ramp;
   reg [5:0]  cfg;
   reg [31:0] position;
   reg [31:0] target;
   reg [6:0]  irq_stat;
   reg [6:0]  irq_mask;
   reg [15:0] speed;
   reg [31:0] phase_acc;
   reg [31:0] pause_cnt;
   reg        leave_ref;
   reg        overtemp_latch;

   // ==========================================================
   // APB slave
   wire wr_en = psel & penable & pwrite;
   wire rd_en = psel & penable & ~pwrite;
   wire addr_ok = (paddr == `OFF_CTRL) | (paddr == `OFF_STATUS) |
                  (paddr == `OFF_IRQ_STAT) | (paddr == `OFF_IRQ_MASK) |
                  (paddr == `OFF_VMIN) | (paddr == `OFF_VMAX) |
                  (paddr == `OFF_RAMP) | (paddr == `OFF_CFG) |
                  (paddr == `OFF_POS) | (paddr == `OFF_TARGET);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;

   wire ctrl_wr   = wr_en & (paddr == `OFF_CTRL);
   wire go_ext    = ctrl_wr & pwdata[`CTRL_START_EXT];
   wire go_int    = ctrl_wr & pwdata[`CTRL_START_INT];
   wire go_pos    = ctrl_wr & pwdata[`CTRL_START_POS];
   wire ack       = ctrl_wr & pwdata[`CTRL_ACK];
   wire abort_req = ctrl_wr & pwdata[`CTRL_ABORT];
   wire invalid   = ctrl_wr & pwdata[`CTRL_INVALID];

   // ==========================================================
   // Switch input conditioning
   reg       sw_meta;
   reg       sw_sync;
   reg [4:0] deb_cnt;
   reg       sw_clean;
   reg       mark_meta;
   reg       mark_sync;
   reg       mark_prev;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_meta   <= 1'b0;
         sw_sync   <= 1'b0;
         deb_cnt   <= 5'h00;
         sw_clean  <= 1'b0;
         mark_meta <= 1'b0;
         mark_sync <= 1'b0;
         mark_prev <= 1'b0;
      end else begin
         sw_meta   <= ref_switch;
         sw_sync   <= sw_meta;
         mark_meta <= shaft_mark;
         mark_sync <= mark_meta;
         mark_prev <= mark_sync;
         if (sw_sync == sw_clean) begin
            deb_cnt <= 5'h00;
         end else if (deb_cnt == `DEBOUNCE_CYC - 1) begin
            deb_cnt  <= 5'h00;
            sw_clean <= sw_sync;
         end else begin
            deb_cnt <= deb_cnt + 5'h01;
         end
      end
   end

   wire sw_active = cfg[`CFG_SW_NC] ? ~sw_clean : sw_clean;
   // mark rising edge once per turn
   wire mark_hit  = mark_sync & ~mark_prev;
   wire [1:0] ref_beh = cfg[`CFG_REF_BEH_HI:`CFG_REF_BEH_LO];
   wire [1:0] nrm_beh = cfg[`CFG_NRM_BEH_HI:`CFG_NRM_BEH_LO];
   // stop/ignore not allowed in reference runs, fall back to reverse
   wire [1:0] ref_eff = ref_beh[1] ? `BEH_REVERSE : ref_beh;

   // ==========================================================
   // Step rate generator
   wire moving = (state == ST_EXT) | (state == ST_LEAVE) | (state == ST_INT) |
                 (state == ST_POS) | (state == ST_LIMLV);
   wire [32:0] acc_sum = {1'b0, phase_acc} + {1'b0, speed, 16'h0000};
   wire tick = moving & acc_sum[32];
   wire at_target = (position == target);

   // stop: the detection cycle issues no step
   wire hard_stop = (state == ST_POS) & sw_active & (nrm_beh == `BEH_STOP);
   wire limit_hit = (state == ST_POS) & sw_active & (nrm_beh != `BEH_IGNORE);

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (go_ext) begin
               next_state = ST_EXT;
            end else if (go_int) begin
               next_state = ST_INT;
            end else if (go_pos) begin
               next_state = ST_POS;
            end
         end
         ST_EXT: begin
            if (sw_active) begin
               next_state = ST_PAUSE;
            end
         end
         ST_PAUSE: begin
            if (pause_cnt == PAUSE_CYCLES - 1) begin
               next_state = ST_LEAVE;
            end
         end
         ST_LEAVE: begin
            if (!sw_active) begin
               next_state = ST_IDLE;
            end
         end
         ST_INT: begin
            if (mark_hit) begin
               next_state = ST_IDLE;
            end
         end
         ST_POS: begin
            if (limit_hit && nrm_beh == `BEH_STOP) begin
               next_state = ST_ERROR;
            end else if (limit_hit) begin
               next_state = ST_LIMLV;
            end else if (position_error) begin
               next_state = ST_ERROR;
            end else if (at_target) begin
               next_state = ST_IDLE;
            end
         end
         ST_LIMLV: begin
            if (!sw_active) begin
               next_state = ST_ERROR;
            end
         end
         ST_ERROR: begin
            if (ack) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // outside the error state, acknowledged invalid data or abort returns ready
      if ((abort_req | (ack & irq_stat[`EV_INVALID])) && state != ST_ERROR) begin
         next_state = ST_IDLE;
      end
   end

   // ==========================================================
   // Sequencer registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= ST_IDLE;
         speed     <= 16'h0000;
         phase_acc <= 32'h0000_0000;
         pause_cnt <= 32'h0000_0000;
         position  <= 32'h0000_0000;
         step      <= 1'b0;
         dir       <= 1'b0;
         leave_ref <= 1'b0;
      end else begin
         state <= next_state;
         step  <= tick & ~hard_stop;
         phase_acc <= moving ? acc_sum[31:0] : 32'h0000_0000;
         if (tick && !hard_stop) begin
            position <= dir ? position - 32'h0000_0001 : position + 32'h0000_0001;
         end
         pause_cnt <= (state == ST_PAUSE) ? pause_cnt + 32'h0000_0001 : 32'h0000_0000;
         case (state)
            ST_IDLE: begin
               speed <= vmin;
               dir   <= cfg[`CFG_DIR];
               if (go_pos) begin
                  dir <= (target < position);
               end
            end
            ST_EXT: begin
               if (tick) begin
                  speed <= (speed + ramp >= vmax) ? vmax : speed + ramp;
               end
               if (sw_active) begin
                  speed <= 16'h0000;
               end
            end
            ST_PAUSE: begin
               speed <= 16'h0000;
               if (pause_cnt == PAUSE_CYCLES - 1) begin
                  speed <= vmin;
                  if (ref_eff == `BEH_REVERSE) begin
                     dir <= ~dir;
                  end
               end
            end
            ST_POS: begin
               if (tick) begin
                  speed <= (speed + ramp >= vmax) ? vmax : speed + ramp;
               end
               if (limit_hit && nrm_beh == `BEH_REVERSE) begin
                  dir <= ~dir;
               end
            end
            ST_INT: begin
               speed <= vmin;
            end
            default: begin
               speed <= speed;
            end
         endcase
      end
   end

   // ==========================================================
   // Reference outputs and errors
   wire ref_reached = ((state == ST_LEAVE) & ~sw_active) | ((state == ST_INT) & mark_hit);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out1 <= 1'b0;
         out2 <= 1'b0;
      end else if (ref_reached || limit_hit) begin
         out1 <= 1'b1;
         out2 <= 1'b1;
      end else if (moving) begin
         out1 <= 1'b0;
         out2 <= 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overtemp_latch <= 1'b0;
      end else if (overtemp) begin
         overtemp_latch <= 1'b1;
      end
   end
   assign error_led = overtemp_latch | undervolt;

   // ==========================================================
   // Interrupt status, write-one-to-clear, set wins
   wire [6:0] events;
   assign events[`EV_REF_DONE]  = ref_reached;
   assign events[`EV_LIMIT]     = limit_hit;
   assign events[`EV_POS_ERR]   = (state == ST_POS) & position_error;
   assign events[`EV_INVALID]   = invalid & (state != ST_IDLE);
   assign events[`EV_OVERTEMP]  = overtemp;
   assign events[`EV_UNDERVOLT] = undervolt;
   assign events[`EV_MOVE_DONE] = (state == ST_POS) & (next_state == ST_IDLE);

   wire stat_wr = wr_en & (paddr == `OFF_IRQ_STAT);

   genvar gi;
   generate
      for (gi = 0; gi < `EV_COUNT; gi = gi + 1) begin : g_irq
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               irq_stat[gi] <= 1'b0;
            end else if (events[gi]) begin
               irq_stat[gi] <= 1'b1;
            end else if ((stat_wr && pwdata[gi]) || (gi == `EV_INVALID && ack)) begin
               irq_stat[gi] <= 1'b0;
            end
         end
      end
   endgenerate
   assign irq = |(irq_stat & irq_mask);

   // ==========================================================
   // Register writes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vmin     <= `VMIN_RESET;
         vmax     <= `VMAX_RESET;
         ramp     <= `RAMP_RESET;
         cfg      <= `CFG_RESET;
         target   <= 32'h0000_0000;
         irq_mask <= 7'h00;
      end else if (wr_en) begin
         case (paddr)
            `OFF_VMIN:     vmin     <= pwdata[15:0];
            `OFF_VMAX:     vmax     <= pwdata[15:0];
            `OFF_RAMP:     ramp     <= pwdata[15:0];
            `OFF_CFG:      cfg      <= pwdata[5:0];
            `OFF_TARGET:   target   <= pwdata;
            `OFF_IRQ_MASK: irq_mask <= pwdata[6:0];
            default:       irq_mask <= irq_mask;
         endcase
      end
   end

   // Read data
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `OFF_STATUS:   prdata <= {16'h0000, state, 5'h00, error_led, sw_active,
                                      state == ST_ERROR};
            `OFF_IRQ_STAT: prdata <= {25'h0000000, irq_stat};
            `OFF_IRQ_MASK: prdata <= {25'h0000000, irq_mask};
            `OFF_VMIN:     prdata <= {16'h0000, vmin};
            `OFF_VMAX:     prdata <= {16'h0000, vmax};
            `OFF_RAMP:     prdata <= {16'h0000, ramp};
            `OFF_CFG:      prdata <= {26'h0000000, cfg};
            `OFF_POS:      prdata <= position;
            `OFF_TARGET:   prdata <= target;
            default:       prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule // ref_limit_motion

`default_nettype wire

// *** verif/ref_limit_motion_checker.sv ***
// Port-level assertions for the reference-run motion core
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Checker
module ref_limit_motion_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        position_error,
   input wire logic        overtemp,
   input wire logic        undervolt,
   input wire logic        step,
   input wire logic        out1,
   input wire logic        out2,
   input wire logic        error_led,
   input wire logic        irq
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   property p_outs_pair;
      out1 == out2;
   endproperty
   a_outs_pair: assert property (p_outs_pair)
      else $error("reference outputs differ");
   property p_temp_latch;
      overtemp |=> error_led;
   endproperty
   a_temp_latch: assert property (p_temp_latch)
      else $error("overtemperature not shown on lamp");
   property p_uv_led;
      undervolt |-> error_led;
   endproperty
   a_uv_led: assert property (p_uv_led)
      else $error("undervoltage not shown on lamp");
   property p_led_hold;
      error_led && !undervolt |=> error_led;
   endproperty
   a_led_hold: assert property (p_led_hold)
      else $error("latched lamp went dark");
   // Error mode must freeze stepping
   property p_err_nostep;
      position_error [*3] |-> !step;
   endproperty
   a_err_nostep: assert property (p_err_nostep)
      else $error("step issued in error mode");
   property p_rst_quiet;
      !$past(presetn) |-> !step && !out1 && !irq;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs active after reset");
   property p_ready;
      psel && penable |-> pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("wait state inserted");
   property p_slverr;
      psel && penable && paddr > 12'h024 |-> pslverr;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("unmapped access not refused");
   c_ref: cover property ($rose(out1));
   c_led: cover property ($rose(error_led));
   c_err: cover property (pslverr);
endmodule // ref_limit_motion_checker

bind ref_limit_motion ref_limit_motion_checker checker_inst (
   .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
   .position_error, .overtemp, .undervolt, .step, .out1, .out2,
   .error_led, .irq);
`default_nettype wire

// *** verif/motor_switch_model.sv ***
// Behavioural switch and shaft model facing the motion core
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Model
module motor_switch_model #(
   parameter int REV   = 64,
   parameter int WIDTH = 20
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               step,
   input  wire logic               dir,
   input  wire logic               nc,
   input  wire logic signed [31:0] sw_base,
   output logic                    ref_switch,
   output logic                    shaft_mark
);
   logic signed [31:0] pos;
   int                 rev;
   logic               hit;
   assign hit        = pos >= sw_base && pos < sw_base + WIDTH;
   assign ref_switch = hit ^ nc;
   // one mark per revolution, wide as one step like a real index
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos <= 0;
         rev <= 0;
         shaft_mark <= 1'h0;
      end else if (step) begin
         pos <= dir ? pos - 1 : pos + 1;
         rev <= (rev == REV - 1) ? 0 : rev + 1;
         shaft_mark <= rev == REV - 1;
      end
   end
endmodule // motor_switch_model
`default_nettype wire

// *** verif/ref_limit_motion_bench.sv ***
// Self-checking bench for the reference-run motion core
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Bench
module ref_limit_motion_bench;
   localparam int PAUSE = 50;
   logic               pclk = 1'h0, presetn = 1'h0, psel = 1'h0;
   logic               penable = 1'h0, pwrite = 1'h0, nc = 1'h0;
   logic               position_error = 1'h0, overtemp = 1'h0, undervolt = 1'h0;
   logic [11:0]        paddr = 12'h0;
   logic [31:0]        pwdata = 32'h0, prdata, rq;
   logic signed [31:0] sw_base = 30;
   logic               pready, pslverr, ref_switch, shaft_mark, err;
   logic               step, dir, out1, out2, error_led, irq;
   logic               ldir = 1'h0;
   int                 fail_count = 0, checks = 0, cyc = 0, p0;
   int                 gap = 0, glast = 0, gmin = 999, gmax = 0, seen = 0;

   ref_limit_motion #(.PAUSE_CYCLES(PAUSE)) ref_limit_motion_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .ref_switch(ref_switch),
      .shaft_mark(shaft_mark), .position_error(position_error),
      .overtemp(overtemp), .undervolt(undervolt), .step(step), .dir(dir),
      .out1(out1), .out2(out2), .error_led(error_led), .irq(irq));
   motor_switch_model motor_switch_model_inst (
      .pclk(pclk), .presetn(presetn), .step(step), .dir(dir), .nc(nc),
      .sw_base(sw_base), .ref_switch(ref_switch), .shaft_mark(shaft_mark));

   initial begin
      forever #2.5 pclk = ~pclk;
   end
   // Step spacing statistics; gap is cycles between two steps
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      gap <= gap + 1;
      if (step === 1'h1) begin
         gap <= 1;
         glast <= gap;
         ldir <= dir;
         if (seen && gap > gmax) gmax <= gap;
         if (seen && gap < gmin) gmin <= gap;
         seen <= 1;
      end
      if (cyc == 40000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic close_out;
      $display("fail_count=%0d checks=%0d", fail_count, checks);
      if (fail_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Off the edge so the stats process never races this clear
   task automatic clr;
      @(posedge pclk);
      #1;
      seen = 0;
      gmin = 999;
      gmax = 0;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rq = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'h0, a, 32'h0);
      chk(rq & m, e);
   endtask
   task automatic wait_irq;
      for (int i = 0; i < 4000 && irq !== 1'h1; i++) @(posedge pclk);
      chk(32'(irq), 32'h1);
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      rd(12'h010, 32'h64, 32'hFFFF);
      rd(12'h014, 32'h3E8, 32'hFFFF);
      rd(12'h018, 32'hA, 32'hFFFF);
      rd(12'h01C, 32'h0, 32'h3F);
      rd(12'h000, 32'h0, 32'hFFFFFFFF);
      rd(12'h040, 32'h0, 32'hFFFFFFFF);
      chk(32'(err), 32'h1);
      wr(12'h010, 32'h1000);
      wr(12'h014, 32'h4000);
      wr(12'h018, 32'h400);
      wr(12'h00C, 32'h09);
      // External runs: reverse with open contact, continue with closed one
      for (int b = 0; b < 2; b++) begin
         wr(12'h01C, 32'({b[1:0], b[0]}));
         nc <= b[0];
         sw_base <= motor_switch_model_inst.pos + 30;
         // Let the debouncer settle on the new polarity before starting
         repeat (24) @(posedge pclk);
         clr();
         wr(12'h000, 32'h1);
         wait_irq();
         chk(32'(gmin >= 4 && gmin < 16), 32'h1);
         chk(32'(gmax > PAUSE), 32'h1);
         chk(32'(glast), 32'd16);
         chk(32'(ldir), 32'(b == 0));
         chk(32'({out1, out2}), 32'h3);
         rd(12'h008, 32'h1, 32'h7F);
         wr(12'h008, 32'h1);
         rd(12'h008, 32'h0, 32'h7F);
         chk(32'(irq), 32'h0);
      end
      // Invalid data during an internal run, then a clean internal run
      wr(12'h000, 32'h2);
      wr(12'h000, 32'h20);
      rd(12'h008, 32'h8, 32'h7F);
      wr(12'h000, 32'h8);
      wr(12'h008, 32'h7F);
      rd(12'h004, 32'h0, 32'h1);
      // A first run ends on the mark, so the second spans one full turn
      wr(12'h000, 32'h2);
      wait_irq();
      wr(12'h008, 32'h7F);
      p0 = motor_switch_model_inst.pos;
      clr();
      wr(12'h000, 32'h2);
      wait_irq();
      chk(32'(gmin == 16 && gmax == 16), 32'h1);
      chk(motor_switch_model_inst.pos - p0, 32'h40);
      wr(12'h008, 32'h7F);
      // Normal-operation behaviours, one positioning move each
      wr(12'h00C, 32'h43);
      nc <= 1'h0;
      repeat (24) @(posedge pclk);
      for (int b = 0; b < 4; b++) begin
         wr(12'h01C, 32'(b << 3));
         sw_base <= motor_switch_model_inst.pos + 10;
         apb(1'h0, 12'h020, 32'h0);
         wr(12'h024, rq + 60);
         wr(12'h000, 32'h4);
         wait_irq();
         repeat (300) @(posedge pclk);
         p0 = motor_switch_model_inst.pos;
         repeat (40) @(posedge pclk);
         chk(motor_switch_model_inst.pos, p0);
         rd(12'h008, b == 3 ? 32'h40 : 32'h02, 32'h42);
         rd(12'h004, 32'(b != 3), 32'h1);
         sw_base <= 32'h100000;
         wr(12'h000, 32'h8);
         wr(12'h008, 32'h7F);
         rd(12'h004, 32'h0, 32'h1);
         // Steps may be lost after a hard stop, so reference again
         if (b == 2) begin
            wr(12'h000, 32'h2);
            wait_irq();
            wr(12'h008, 32'h7F);
         end
      end
      // Position error with its event masked first
      apb(1'h0, 12'h020, 32'h0);
      wr(12'h024, rq + 200);
      wr(12'h000, 32'h4);
      position_error <= 1'h1;
      rd(12'h008, 32'h4, 32'h4);
      chk(32'(irq), 32'h0);
      wr(12'h00C, 32'h04);
      rd(12'h004, 32'h1, 32'h1);
      chk(32'(irq), 32'h1);
      position_error <= 1'h0;
      wr(12'h000, 32'h8);
      wr(12'h008, 32'h7F);
      rd(12'h004, 32'h0, 32'h1);
      // Lamp: undervoltage follows the level, overtemperature latches
      undervolt <= 1'h1;
      rd(12'h004, 32'h4, 32'h4);
      undervolt <= 1'h0;
      rd(12'h004, 32'h0, 32'h4);
      overtemp <= 1'h1;
      @(posedge pclk);
      overtemp <= 1'h0;
      wr(12'h000, 32'h8);
      rd(12'h004, 32'h4, 32'h4);
      chk(32'(error_led), 32'h1);
      presetn <= 1'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      rd(12'h004, 32'h0, 32'h4);
      close_out();
   end
endmodule // ref_limit_motion_bench
`default_nettype wire
